// [rtl/drpr_defines.svh]
`ifndef DRPR_DEFINES_SVH
`define DRPR_DEFINES_SVH
// ----------------------------------------------------------------------
// Register map.
// ----------------------------------------------------------------------
`define DRPR_OFF_KPB   6'h00
`define DRPR_OFF_UDB   6'h04
`define DRPR_OFF_UPB   6'h08
`define DRPR_OFF_SIZE  6'h0C
// ----------------------------------------------------------------------
// Field layout and reset values.
// ----------------------------------------------------------------------
`define DRPR_BASE_MSB  15
`define DRPR_BASE_LSB  10
`define DRPR_BASE_RST  6'h00
`define DRPR_RAM_SIZE  32'h00008000
`define DRPR_RESP_OK   2'h0
`define DRPR_RESP_ERR  2'h2
`endif

// [rtl/drpr_pkg.sv]
package drpr_pkg;
  // Index of the three writable base registers.
  typedef enum logic [1:0] {DRPR_KPB, DRPR_UDB, DRPR_UPB} drpr_sel_t;
  typedef logic [5:0] drpr_field_t;
endpackage : drpr_pkg

// [rtl/drpr_base_if.sv]
// Carries one base write between the bus slave and the field store.
interface drpr_base_if;
  logic [2:0] wr_en;
  logic [5:0] wr_field;
  logic [5:0] field0;
  logic [5:0] field1;
  logic [5:0] field2;
  modport store (input wr_en, input wr_field,
                 output field0, output field1, output field2);
  modport ctrl  (output wr_en, output wr_field,
                 input field0, input field1, input field2);
endinterface : drpr_base_if

// [rtl/drpr_base_store.sv]
`include "drpr_defines.svh"
// ----------------------------------------------------------------------
// Three 6-bit base fields, cleared by reset.
// ----------------------------------------------------------------------
module drpr_base_store (
  input  wire logic  aclk,     // System clock.
  input  wire logic  aresetn,  // Synchronous reset, active low.
  input  wire logic  ce,       // Clock enable.
  drpr_base_if.store bus       // Write port and field outputs.
);
  logic [5:0] field_r [3];

  // Each field loads only on its own strobe.
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_f
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          field_r[g] <= `DRPR_BASE_RST;
        end else if (ce && bus.wr_en[g]) begin
          field_r[g] <= bus.wr_field;
        end
      end
    end
  endgenerate

  assign bus.field0 = field_r[0];
  assign bus.field1 = field_r[1];
  assign bus.field2 = field_r[2];
endmodule : drpr_base_store

// [rtl/drpr_regs.sv]
// The register offsets and the AXI4-Lite interface to the registers were decided locally.
`include "drpr_defines.svh"
module drpr_regs #(
  parameter logic [31:0] RAM_SIZE = `DRPR_RAM_SIZE  // 4, 8, 16 or 32 KB.
) (
  input  wire logic        aclk,          // System clock.
  input  wire logic        aresetn,       // Synchronous reset, active low.
  input  wire logic        ce,            // Clock enable, freezes state.
  input  wire logic [5:0]  s_awaddr,      // Write address.
  input  wire logic        s_awvalid,     // Write address valid.
  output logic             s_awready,     // Write address ready.
  input  wire logic [31:0] s_wdata,       // Write data.
  input  wire logic [3:0]  s_wstrb,       // Write byte strobes.
  input  wire logic        s_wvalid,      // Write data valid.
  output logic             s_wready,      // Write data ready.
  output logic [1:0]       s_bresp,       // Write response.
  output logic             s_bvalid,      // Write response valid.
  input  wire logic        s_bready,      // Write response ready.
  input  wire logic [5:0]  s_araddr,      // Read address.
  input  wire logic        s_arvalid,     // Read address valid.
  output logic             s_arready,     // Read address ready.
  output logic [31:0]      s_rdata,       // Read data.
  output logic [1:0]       s_rresp,       // Read response.
  output logic             s_rvalid,      // Read data valid.
  input  wire logic        s_rready,      // Read data ready.
  output logic [15:0]      kdata_end,     // Kernel data end, bytes.
  output logic [15:0]      kprog_base,    // Kernel program start, bytes.
  output logic [15:0]      udata_base,    // User data start, bytes.
  output logic [15:0]      uprog_base     // User program start, bytes.
);
  // --------------------------------------------------------------------
  // Write channel.
  // --------------------------------------------------------------------
  drpr_base_if bif ();

  logic        aw_have_r;
  logic        w_have_r;
  logic [5:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;
  logic        wr_go;
  logic [5:0]  wr_a;
  logic [31:0] wr_d;
  logic [3:0]  wr_s;

  // Ready stays low while the clock enable is low, because a frozen slave
  // could not capture what a completed handshake hands it.
  assign s_awready = aw_have_r == 1'b0 && s_bvalid == 1'b0 && aresetn &&
                     ce;
  assign s_wready  = w_have_r == 1'b0 && s_bvalid == 1'b0 && aresetn &&
                     ce;

  // Address and data may arrive in either order or together.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_have_r <= 1'b0;
      w_have_r  <= 1'b0;
      aw_addr_r <= 6'h00;
      w_data_r  <= 32'h00000000;
      w_strb_r  <= 4'h0;
    end else if (ce) begin
      if (wr_go) begin
        aw_have_r <= 1'b0;
        w_have_r  <= 1'b0;
      end else begin
        if (s_awvalid && s_awready) begin
          aw_have_r <= 1'b1;
          aw_addr_r <= s_awaddr;
        end
        if (s_wvalid && s_wready) begin
          w_have_r <= 1'b1;
          w_data_r <= s_wdata;
          w_strb_r <= s_wstrb;
        end
      end
    end
  end

  // A write completes once both halves are known.
  always_comb begin
    wr_a  = aw_have_r ? aw_addr_r : s_awaddr;
    wr_d  = w_have_r ? w_data_r : s_wdata;
    wr_s  = w_have_r ? w_strb_r : s_wstrb;
    wr_go = (aw_have_r || (s_awvalid && s_awready)) &&
            (w_have_r || (s_wvalid && s_wready));
  end

  // Only byte lane 1 holds writable bits; other lanes are ignored.
  always_comb begin
    bif.wr_en    = 3'h0;
    bif.wr_field = wr_d[`DRPR_BASE_MSB:`DRPR_BASE_LSB];
    if (wr_go && wr_s[1]) begin
      case (wr_a[5:2])
        4'h0:    bif.wr_en[drpr_pkg::DRPR_KPB] = 1'b1;
        4'h1:    bif.wr_en[drpr_pkg::DRPR_UDB] = 1'b1;
        4'h2:    bif.wr_en[drpr_pkg::DRPR_UPB] = 1'b1;
        default: bif.wr_en = 3'h0;
      endcase
    end
  end

  drpr_base_store u_store (
    .aclk    (aclk),
    .aresetn (aresetn),
    .ce      (ce),
    .bus     (bif)
  );

  // Response: unmapped addresses get SLVERR, the size register ignores.
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_bvalid <= 1'b0;
      s_bresp  <= `DRPR_RESP_OK;
    end else if (ce) begin
      if (wr_go) begin
        s_bvalid <= 1'b1;
        s_bresp  <= (wr_a[5:2] <= 4'h3) ? `DRPR_RESP_OK : `DRPR_RESP_ERR;
      end else if (s_bready) begin
        s_bvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Read channel.
  // --------------------------------------------------------------------
  assign s_arready = s_rvalid == 1'b0 && aresetn && ce;

  // Base fields sit in bits 15:10; all other bits return zero.
  function automatic logic [31:0] base_word(input logic [5:0] f);
    base_word = {16'h0000, f, 10'h000};
  endfunction : base_word

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_rvalid <= 1'b0;
      s_rdata  <= 32'h00000000;
      s_rresp  <= `DRPR_RESP_OK;
    end else if (ce) begin
      if (s_arvalid && s_arready) begin
        s_rvalid <= 1'b1;
        s_rresp  <= `DRPR_RESP_OK;
        case (s_araddr[5:2])
          4'h0:    s_rdata <= base_word(bif.field0);
          4'h1:    s_rdata <= base_word(bif.field1);
          4'h2:    s_rdata <= base_word(bif.field2);
          4'h3:    s_rdata <= RAM_SIZE;
          default: begin
            s_rdata <= 32'h00000000;
            s_rresp <= `DRPR_RESP_ERR;
          end
        endcase
      end else if (s_rready) begin
        s_rvalid <= 1'b0;
      end
    end
  end

  // --------------------------------------------------------------------
  // Region boundaries for the access checker.
  // --------------------------------------------------------------------
  logic [15:0] kp_b;
  logic [15:0] ud_b;
  logic [15:0] up_b;
  logic [15:0] first_nz;

  // A zero base means the region is absent, so kernel data runs to the
  // first programmed base or, with none, to the end of RAM.
  always_comb begin
    kp_b = {bif.field0, 10'h000};
    ud_b = {bif.field1, 10'h000};
    up_b = {bif.field2, 10'h000};
    if (kp_b != 16'h0000) begin
      first_nz = kp_b;
    end else if (ud_b != 16'h0000) begin
      first_nz = ud_b;
    end else if (up_b != 16'h0000) begin
      first_nz = up_b;
    end else begin
      first_nz = RAM_SIZE[15:0]; // 32 KB still fits in 16 bits.
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      kdata_end  <= RAM_SIZE[15:0];
      kprog_base <= 16'h0000;
      udata_base <= 16'h0000;
      uprog_base <= 16'h0000;
    end else if (ce) begin
      kdata_end  <= first_nz;
      kprog_base <= kp_b;
      udata_base <= ud_b;
      uprog_base <= up_b;
    end
  end

  // --------------------------------------------------------------------
  // Checks.
  // --------------------------------------------------------------------
  a_base_low_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && s_arvalid && s_arready && s_araddr[5:2] <= 4'h2 |=>
    s_rdata[9:0] == 10'h000)
    else $error("base low bits nonzero");
  a_read_high_zero: assert property (@(posedge aclk) disable iff (!aresetn)
    $rose(s_rvalid) && s_rresp == `DRPR_RESP_OK &&
    s_rdata != RAM_SIZE |-> s_rdata[31:16] == 16'h0000 &&
    s_rdata[9:0] == 10'h000)
    else $error("base read reserved bits nonzero");
  a_reset_clear: assert property (@(posedge aclk)
    !aresetn |=> kprog_base == 16'h0000 && udata_base == 16'h0000 &&
    uprog_base == 16'h0000)
    else $error("bases not cleared by reset");
  a_kp_write: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && bif.wr_en[0] |=> bif.field0 == $past(bif.wr_field))
    else $error("kernel program base not written");
  a_ud_write: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && bif.wr_en[1] |=> bif.field1 == $past(bif.wr_field))
    else $error("user data base not written");
  a_up_write: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && bif.wr_en[2] |=> bif.field2 == $past(bif.wr_field))
    else $error("user program base not written");
  a_size_read: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && s_arvalid && s_arready && s_araddr[5:2] == 4'h3 |=>
    s_rvalid && s_rdata == RAM_SIZE)
    else $error("size read wrong");
  a_kdata_bound: assert property (@(posedge aclk) disable iff (!aresetn)
    ce ##1 ce && $stable(kp_b) && kp_b != 16'h0000 |-> kdata_end == kp_b)
    else $error("kernel data end wrong");
  a_bresp_one: assert property (@(posedge aclk) disable iff (!aresetn)
    ce && wr_go |=> s_bvalid)
    else $error("no write response");
  c_write_kp: cover property (@(posedge aclk) bif.wr_en[0]);
  c_read_size: cover property (@(posedge aclk)
    $rose(s_rvalid) && s_rdata == RAM_SIZE);
  c_all_set: cover property (@(posedge aclk) kp_b != 16'h0000 &&
    ud_b > kp_b && up_b > ud_b);
  c_bad_addr: cover property (@(posedge aclk) s_bvalid &&
    s_bresp == `DRPR_RESP_ERR);
endmodule : drpr_regs

// [verif/drpr_regs_tb.sv]
`include "drpr_defines.svh"
// Compares two values, counting the check and reporting a mismatch.
`define CHK(got, exp) begin tests_run++; if ((got) !== (exp)) begin \
  n_fail++; $display("[FAIL] t=%0t got=%0h exp=%0h", $time, got, exp); \
  end end
module drpr_regs_tb;
  timeunit 1ns;
  timeprecision 1ps;
  // ----------------------------------------------------------------------
  // Signals.
  // ----------------------------------------------------------------------
  logic        aclk, aresetn, ce;
  logic [5:0]  s_awaddr, s_araddr;
  logic        s_awvalid, s_awready, s_wvalid, s_wready;
  logic [31:0] s_wdata, s_rdata;
  logic [3:0]  s_wstrb;
  logic [1:0]  s_bresp, s_rresp, resp;
  logic        s_bvalid, s_bready, s_arvalid, s_arready, s_rvalid, s_rready;
  logic [15:0] kdata_end, kprog_base, udata_base, uprog_base;
  logic [31:0] rd;
  int          n_fail, tests_run;

  drpr_regs DUT (
    .aclk(aclk), .aresetn(aresetn), .ce(ce),
    .s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
    .s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid),
    .s_wready(s_wready), .s_bresp(s_bresp), .s_bvalid(s_bvalid),
    .s_bready(s_bready), .s_araddr(s_araddr), .s_arvalid(s_arvalid),
    .s_arready(s_arready), .s_rdata(s_rdata), .s_rresp(s_rresp),
    .s_rvalid(s_rvalid), .s_rready(s_rready), .kdata_end(kdata_end),
    .kprog_base(kprog_base), .udata_base(udata_base),
    .uprog_base(uprog_base));

  // A 200 MHz clock.
  initial begin
    aclk = 1'b0;
    forever #2.5 aclk = ~aclk;
  end

  // ----------------------------------------------------------------------
  // Bus tasks.
  // ----------------------------------------------------------------------
  // Ends the run; every hang and the normal finish come through here.
  task automatic close_out;
    $display("Checks run %0d, mismatches %0d", tests_run, n_fail);
    if (n_fail == 0 && tests_run > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : close_out

  // Address and data go out together; the response is waited for.
  task automatic axi_wr(input logic [5:0] a, input logic [31:0] d,
                        output logic [1:0] r);
    int n;
    bit aw_ok, w_ok, done;
    @(posedge aclk);
    s_awaddr <= a; s_awvalid <= 1'b1; s_wdata <= d; s_wvalid <= 1'b1;
    s_bready <= 1'b1;
    aw_ok = 0; w_ok = 0; done = 0; n = 0;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_bvalid === 1'b1) begin
        r = s_bresp; s_bready <= 1'b0; done = 1;
      end
      if (!aw_ok && s_awready === 1'b1) begin
        aw_ok = 1; s_awvalid <= 1'b0;
      end
      if (!w_ok && s_wready === 1'b1) begin
        w_ok = 1; s_wvalid <= 1'b0;
      end
      if (n > 50) begin
        n_fail++; close_out();
      end
    end
  endtask : axi_wr

  // Holds the request until taken, then waits for the read data.
  task automatic axi_rd(input logic [5:0] a, output logic [31:0] d,
                        output logic [1:0] r);
    int n;
    bit ar_ok, done;
    @(posedge aclk);
    s_araddr <= a; s_arvalid <= 1'b1; s_rready <= 1'b1;
    ar_ok = 0; done = 0; n = 0;
    while (!done) begin
      @(posedge aclk);
      n++;
      if (s_rvalid === 1'b1) begin
        d = s_rdata; r = s_rresp; s_rready <= 1'b0; done = 1;
      end
      if (!ar_ok && s_arready === 1'b1) begin
        ar_ok = 1; s_arvalid <= 1'b0;
      end
      if (n > 50) begin
        n_fail++; close_out();
      end
    end
  endtask : axi_rd

  // Reads one register and compares data and response.
  task automatic rd_chk(input logic [5:0] a, input logic [31:0] e);
    axi_rd(a, rd, resp);
    `CHK(rd, e)
    `CHK(resp, `DRPR_RESP_OK)
  endtask : rd_chk

  task automatic do_reset;
    @(posedge aclk);
    aresetn <= 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
  endtask : do_reset

  // ----------------------------------------------------------------------
  // Main sequence.
  // ----------------------------------------------------------------------
  initial begin
    n_fail = 0; tests_run = 0; aresetn = 1'b0; ce = 1'b1;
    s_awaddr = 6'h00; s_awvalid = 1'b0; s_wdata = 32'h00000000;
    s_wstrb = 4'hF; s_wvalid = 1'b0; s_bready = 1'b0; s_araddr = 6'h00;
    s_arvalid = 1'b0; s_rready = 1'b0;
    repeat (2) @(posedge aclk);
    aresetn <= 1'b1;
    // Reset state: bases clear, size static, all RAM kernel data.
    rd_chk(`DRPR_OFF_KPB, 32'h00000000);
    rd_chk(`DRPR_OFF_UDB, 32'h00000000);
    rd_chk(`DRPR_OFF_UPB, 32'h00000000);
    rd_chk(`DRPR_OFF_SIZE, 32'h00008000);
    `CHK(kdata_end, 16'h8000)
    // Ascending bases below the size; junk in read-only bits.
    axi_wr(`DRPR_OFF_KPB, 32'h000023FF, resp);
    `CHK(resp, `DRPR_RESP_OK)
    axi_wr(`DRPR_OFF_UDB, 32'hFFFF43FF, resp);
    axi_wr(`DRPR_OFF_UPB, 32'hA5A567FF, resp);
    rd_chk(`DRPR_OFF_KPB, 32'h00002000);
    rd_chk(`DRPR_OFF_UDB, 32'h00004000);
    rd_chk(`DRPR_OFF_UPB, 32'h00006400);
    `CHK(kdata_end, 16'h2000)
    `CHK(kprog_base, 16'h2000)
    `CHK(udata_base, 16'h4000)
    `CHK(uprog_base, 16'h6400)
    // A write without byte lane 1 stores nothing.
    s_wstrb <= 4'hD;
    axi_wr(`DRPR_OFF_KPB, 32'h00007C00, resp);
    s_wstrb <= 4'hF;
    `CHK(resp, `DRPR_RESP_OK)
    rd_chk(`DRPR_OFF_KPB, 32'h00002000);
    // The size register ignores writes.
    axi_wr(`DRPR_OFF_SIZE, 32'h00001000, resp);
    `CHK(resp, `DRPR_RESP_OK)
    rd_chk(`DRPR_OFF_SIZE, 32'h00008000);
    // Unmapped place: error response and zero data.
    axi_rd(6'h10, rd, resp);
    `CHK(rd, 32'h00000000)
    `CHK(resp, `DRPR_RESP_ERR)
    axi_wr(6'h14, 32'hFFFFFFFF, resp);
    `CHK(resp, `DRPR_RESP_ERR)
    // A second reset in mid-run returns all RAM to kernel data.
    do_reset();
    rd_chk(`DRPR_OFF_UPB, 32'h00000000);
    `CHK(kdata_end, 16'h8000)
    `CHK(uprog_base, 16'h0000)
    // With only the user data base set, kernel data ends there.
    axi_wr(`DRPR_OFF_UDB, 32'h00001000, resp);
    repeat (3) @(posedge aclk);
    `CHK(kdata_end, 16'h1000)
    `CHK(udata_base, 16'h1000)
    // Clock enable low: the bus stalls and nothing moves until it returns.
    ce <= 1'b0;
    fork
      axi_wr(`DRPR_OFF_UDB, 32'h00002000, resp);
      begin
        repeat (4) @(posedge aclk);
        `CHK(s_awready, 1'b0)
        `CHK(udata_base, 16'h1000)
        ce <= 1'b1;
      end
    join
    `CHK(resp, `DRPR_RESP_OK)
    rd_chk(`DRPR_OFF_UDB, 32'h00002000);
    `CHK(kdata_end, 16'h2000)
    close_out();
  end
endmodule : drpr_regs_tb
